// File: verilog/sef_port.sv
`timescale 1ns/1ps
`include "sef_defines.svh"
module sef_port (
    input wire logic clk, // cpu clock
    input wire logic rst_n, // async reset, active low
    input wire logic link_sck, // serial clock from remote master
    input wire logic halt, // cpu in halt
    input wire logic cr_wr, // control register write strobe
    input wire logic csr_rd, // status register read strobe
    input wire logic dr_wr, // data register write strobe
    input wire logic dr_rd, // data register read strobe
    input wire sef_pkg::sef_byte_t wdata, // write data
    output sef_pkg::sef_byte_t cr_rdata, // control register
    output sef_pkg::sef_byte_t csr_rdata, // status register
    output sef_pkg::sef_byte_t dr_rdata, // receive buffer
    output logic irq, // interrupt request, also wakes from wait
    output logic halt_wake, // wake-up from halt
    input wire logic ss_n, // slave select pin, active low
    input wire logic miso_in, // master-in pin level
    output logic miso_out, // slave-out drive
    output logic miso_oe, // slave-out enable
    input wire logic mosi_in, // slave-in pin level
    output logic mosi_out, // master-out drive
    output logic mosi_oe, // master-out enable
    output logic sck_out, // master serial clock drive
    output logic sck_oe // master serial clock enable
);
    import sef_pkg::*;

    sef_byte_t cr_reg, cr_next;
    logic tc_reg, tc_arm_reg, overrun_reg, coll_reg, coll_arm_reg;
    logic fault_reg, fault_arm_reg;
    sef_byte_t rx_buf_reg, tx_hold_reg;
    logic ss_m, ss_s, miso_m, miso_s;
    logic mid_m, mid_s, tg_m, tg_s, tg_d;
    sef_state_e st_reg;
    logic [6:0] half_reg;
    logic [4:0] edge_reg;
    logic phase_reg, mo_reg;
    sef_byte_t msh_reg;
    logic [2:0] cnt_reg, lcnt_reg;
    logic [6:0] rsh_reg;
    sef_byte_t rx_word_reg;
    logic done_tgl_reg;

    function automatic logic [6:0] half_of(input logic [2:0] spr);
        case (spr)
            3'b100: half_of = `SEF_HALF_DIV4;
            3'b000: half_of = `SEF_HALF_DIV8;
            3'b001: half_of = `SEF_HALF_DIV16;
            3'b110: half_of = `SEF_HALF_DIV32;
            3'b010: half_of = `SEF_HALF_DIV64;
            default: half_of = `SEF_HALF_DIV128;
        endcase
    endfunction

    wire ie = cr_reg[`SEF_CR_IE];
    wire en = cr_reg[`SEF_CR_EN];
    wire master_select = cr_reg[`SEF_CR_MASTER];
    wire clock_polarity = cr_reg[`SEF_CR_POLARITY];
    wire clock_phase = cr_reg[`SEF_CR_PHASE];
    wire [2:0] spr = {cr_reg[`SEF_CR_SPR2], cr_reg[`SEF_CR_SPR1],
                      cr_reg[`SEF_CR_SPR0]};
    wire [6:0] half_load = half_of(spr) - 7'h01;
    wire master_on = en & master_select;
    wire slave_on = en & ~master_select;

    // cpu strobes are ignored while halted, the cpu is stopped anyway
    wire run = ~halt;
    wire c_csr_rd = csr_rd & run;
    wire c_cr_wr = cr_wr & run;
    wire c_dr_wr = dr_wr & run;
    wire c_dr_rd = dr_rd & run;
    wire dr_acc = c_dr_wr | c_dr_rd;

    // fault only as master
    // a fault waits for halt to end, control is frozen until then
    wire fault_ev = master_on & ~ss_s & run;
    wire fault_clr = fault_arm_reg & c_cr_wr;

    wire slave_busy = slave_on & ~ss_s & (~clock_phase | mid_s);
    wire busy = (st_reg == SEF_RUN) | slave_busy;
    wire dr_inhibit = tc_reg & ~tc_arm_reg;
    wire dr_take = c_dr_wr & ~busy & ~dr_inhibit;

    // master edge timing
    wire m_tick = (st_reg == SEF_RUN) & (half_reg == 7'h00) & run;
    wire m_cap = (edge_reg[0] == clock_phase);
    wire m_done = m_tick & (edge_reg == `SEF_LAST_EDGE) & ~fault_ev;
    wire [7:0] m_byte = clock_phase ? {msh_reg[6:0], miso_s} : msh_reg;

    wire s_done = tg_s ^ tg_d;
    wire done = m_done | s_done;
    wire [7:0] done_byte = m_done ? m_byte : rx_word_reg;

    // transfer flag set wins over clear
    wire tc_clr = tc_arm_reg & dr_acc;
    wire tc_next = done | (tc_reg & ~tc_clr);
    wire tc_arm_next = tc_next & ~tc_clr &
                       (tc_arm_reg | (c_csr_rd & tc_reg));
    // byte done with flag still set
    wire overrun_ev = done & tc_reg;
    wire overrun_next = overrun_ev | (overrun_reg & ~c_csr_rd);
    wire coll_ev = c_dr_wr & busy;
    wire coll_clr = coll_arm_reg & dr_acc;
    wire coll_next = coll_ev | (coll_reg & ~coll_clr);
    wire coll_arm_next = coll_next & ~coll_clr &
                         (coll_arm_reg | (c_csr_rd & coll_reg));
    wire fault_next = fault_ev | (fault_reg & ~fault_clr);
    wire fault_arm_next = fault_next & ~fault_clr &
                          (fault_arm_reg | (c_csr_rd & fault_reg));

    // enable and master refused while fault pending, until a status read arms the clear
    wire cr_block = fault_reg & ~fault_arm_reg;
    always_comb begin
        cr_next = cr_reg;
        if (c_cr_wr) begin
            cr_next = wdata;
            if (cr_block) begin
                cr_next[`SEF_CR_EN] = 1'b0;
                cr_next[`SEF_CR_MASTER] = 1'b0;
            end
        end
        if (fault_ev) begin
            cr_next[`SEF_CR_EN] = 1'b0;
            cr_next[`SEF_CR_MASTER] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cr_reg <= `SEF_CR_RESET;
        end else if (run) begin
            cr_reg <= cr_next;
        end
    end

    // status flags keep logging slave bytes during halt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tc_reg <= 1'b0;
            tc_arm_reg <= 1'b0;
            overrun_reg <= 1'b0;
            coll_reg <= 1'b0;
            coll_arm_reg <= 1'b0;
            fault_reg <= 1'b0;
            fault_arm_reg <= 1'b0;
        end else begin
            tc_reg <= tc_next;
            tc_arm_reg <= tc_arm_next;
            overrun_reg <= overrun_next;
            coll_reg <= coll_next;
            coll_arm_reg <= coll_arm_next;
            fault_reg <= fault_next;
            fault_arm_reg <= fault_arm_next;
        end
    end

    // buffer keeps first byte on overrun
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_buf_reg <= 8'h00;
        end else if (done & ~tc_reg) begin
            rx_buf_reg <= done_byte;
        end
    end

    // echo of received byte unless reloaded
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_hold_reg <= 8'h00;
        end else if (dr_take) begin
            tx_hold_reg <= wdata;
        end else if (s_done) begin
            tx_hold_reg <= rx_word_reg;
        end
    end

    // pin and cross-domain synchronisers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ss_m <= 1'b1;
            ss_s <= 1'b1;
            miso_m <= 1'b0;
            miso_s <= 1'b0;
            mid_m <= 1'b0;
            mid_s <= 1'b0;
            tg_m <= 1'b0;
            tg_s <= 1'b0;
            tg_d <= 1'b0;
        end else begin
            ss_m <= ss_n;
            ss_s <= ss_m;
            miso_m <= miso_in;
            miso_s <= miso_m;
            mid_m <= (cnt_reg != 3'h0);
            mid_s <= mid_m;
            tg_m <= done_tgl_reg;
            tg_s <= tg_m;
            tg_d <= tg_s;
        end
    end

    // master engine; sck made from clk by a divider
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= SEF_IDLE;
            half_reg <= 7'h00;
            edge_reg <= 5'h00;
            phase_reg <= 1'b0;
            mo_reg <= 1'b0;
            msh_reg <= 8'h00;
        end else if (fault_ev) begin
            st_reg <= SEF_IDLE;
            phase_reg <= 1'b0;
        end else if (run) begin
            unique case (st_reg)
                SEF_IDLE: begin
                    if (dr_take & master_on) begin
                        st_reg <= SEF_RUN;
                        half_reg <= half_load;
                        edge_reg <= 5'h00;
                        phase_reg <= 1'b0;
                        msh_reg <= wdata;
                        mo_reg <= wdata[7];
                    end
                end
                SEF_RUN: begin
                    if (m_tick) begin
                        half_reg <= half_load;
                        phase_reg <= ~phase_reg;
                        edge_reg <= edge_reg + 5'h01;
                        if (m_cap) begin
                            msh_reg <= {msh_reg[6:0], miso_s};
                        end else begin
                            mo_reg <= msh_reg[7];
                        end
                        if (edge_reg == `SEF_LAST_EDGE) begin
                            st_reg <= SEF_IDLE;
                        end
                    end else begin
                        half_reg <= half_reg - 7'h01;
                    end
                end
            endcase
        end
    end

    // slave link domain; polarity and phase are static while enabled
    // config changed only with the port off
    wire cap_clk = link_sck ^ (clock_polarity ^ clock_phase);
    wire link_rst_n = rst_n & slave_on & ~ss_n;
    wire [2:0] out_idx = clock_phase ? (lcnt_reg - 3'h1) : lcnt_reg;

    always_ff @(posedge cap_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            cnt_reg <= 3'h0;
            rsh_reg <= 7'h00;
        end else begin
            cnt_reg <= cnt_reg + 3'h1;
            rsh_reg <= {rsh_reg[5:0], mosi_in};
        end
    end

    // completion word and toggle survive slave select release
    always_ff @(posedge cap_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_word_reg <= 8'h00;
            done_tgl_reg <= 1'b0;
        end else if (link_rst_n & (cnt_reg == 3'h7)) begin
            rx_word_reg <= {rsh_reg, mosi_in};
            done_tgl_reg <= ~done_tgl_reg;
        end
    end

    always_ff @(negedge cap_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lcnt_reg <= 3'h0;
        end else begin
            lcnt_reg <= lcnt_reg + 3'h1;
        end
    end

    assign miso_out = tx_hold_reg[3'h7 - out_idx];
    assign miso_oe = slave_on & ~ss_s;
    assign mosi_out = mo_reg;
    assign mosi_oe = master_on;
    assign sck_out = clock_polarity ^ phase_reg;
    assign sck_oe = master_on;

    assign cr_rdata = cr_reg;
    assign csr_rdata = {tc_reg, coll_reg, overrun_reg, fault_reg, 4'h0};
    assign dr_rdata = rx_buf_reg;
    assign irq = ie & (tc_reg | overrun_reg | fault_reg);
    assign halt_wake = ie & tc_reg & halt;
endmodule

// File: pkg/sef_defines.svh
`ifndef SEF_DEFINES_SVH
`define SEF_DEFINES_SVH
`define SEF_CR_IE 7
`define SEF_CR_EN 6
`define SEF_CR_SPR2 5
`define SEF_CR_MASTER 4
`define SEF_CR_POLARITY 3
`define SEF_CR_PHASE 2
`define SEF_CR_SPR1 1
`define SEF_CR_SPR0 0
`define SEF_CR_RESET 8'h00
`define SEF_CSR_TC 7
`define SEF_CSR_COLLISION 6
`define SEF_CSR_OVERRUN 5
`define SEF_CSR_FAULT 4
`define SEF_HALF_DIV4 7'h02
`define SEF_HALF_DIV8 7'h04
`define SEF_HALF_DIV16 7'h08
`define SEF_HALF_DIV32 7'h10
`define SEF_HALF_DIV64 7'h20
`define SEF_HALF_DIV128 7'h40
`define SEF_LAST_EDGE 5'h0f
`endif

// File: pkg/sef_pkg.sv
package sef_pkg;
    typedef enum logic [0:0] {
        SEF_IDLE = 1'b0,
        SEF_RUN = 1'b1
    } sef_state_e;
    typedef logic [7:0] sef_byte_t;
endpackage

// File: testbench/sef_port_assertions.sv
`timescale 1ns/1ps
module sef_port_assertions (
    input wire logic clk, // cpu clock
    input wire logic rst_n, // async reset, active low
    input wire logic halt, // cpu in halt
    input wire logic cr_wr, // control write strobe
    input wire logic csr_rd, // status read strobe
    input wire logic dr_wr, // data write strobe
    input wire logic dr_rd, // data read strobe
    input sef_pkg::sef_byte_t cr_rdata, // control register
    input sef_pkg::sef_byte_t csr_rdata, // status register
    input sef_pkg::sef_byte_t dr_rdata, // receive buffer
    input logic irq, // interrupt request
    input logic halt_wake // halt wake-up
);
    import sef_pkg::*;
    logic armed_reg;
    logic armed_next;
    // a status read while faulted arms the clearing write
    assign armed_next = (csr_rd && !halt && csr_rdata[4]) ||
                        (armed_reg && csr_rdata[4]);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_reg <= 1'b0;
        end else begin
            armed_reg <= armed_next;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    irq_on_error_a: assert property (
        cr_rdata[7] && (csr_rdata[4] || csr_rdata[5]) |-> irq)
        else $error("irq missing with error flag");
    coll_no_irq_a: assert property (
        !(csr_rdata[7] || csr_rdata[5] || csr_rdata[4]) |-> !irq)
        else $error("irq without cause");
    fault_drops_ctrl_a: assert property (
        $rose(csr_rdata[4]) |-> !cr_rdata[6] && !cr_rdata[4])
        else $error("fault kept enable or master");
    fault_master_only_a: assert property (
        $rose(csr_rdata[4]) |-> $past(cr_rdata[4]) && $past(cr_rdata[6]))
        else $error("fault raised outside master mode");
    fault_blocks_set_a: assert property (
        cr_wr && !halt && csr_rdata[4] && !armed_reg
        |=> !cr_rdata[6] && !cr_rdata[4])
        else $error("enable set while faulted");
    fault_clear_seq_a: assert property (
        $fell(csr_rdata[4])
        |-> $past(cr_wr) && !$past(halt) && $past(armed_reg))
        else $error("fault cleared out of sequence");
    overrun_after_done_a: assert property (
        $rose(csr_rdata[5]) |-> $past(csr_rdata[7]))
        else $error("overrun without pending byte");
    buf_hold_a: assert property (
        $past(csr_rdata[7]) && csr_rdata[7] |-> $stable(dr_rdata))
        else $error("buffer changed while byte pending");
    overrun_clear_a: assert property (
        csr_rd && !halt && csr_rdata[5] |=> !csr_rdata[5])
        else $error("overrun not cleared by status read");
    done_clear_a: assert property (
        $fell(csr_rdata[7]) |-> $past(dr_rd) || $past(dr_wr))
        else $error("done flag cleared without data access");
    halt_freeze_a: assert property (
        halt && $past(halt)
        |-> $stable(cr_rdata) && (!halt_wake || csr_rdata[7]))
        else $error("control changed in halt");
    cover property ($rose(csr_rdata[5]));
    cover property ($rose(csr_rdata[4]));
    cover property ($rose(csr_rdata[6]));
endmodule
bind sef_port sef_port_assertions u_sef_port_assertions (.clk, .rst_n,
    .halt, .cr_wr, .csr_rd, .dr_wr, .dr_rd, .cr_rdata, .csr_rdata,
    .dr_rdata, .irq, .halt_wake);

// File: testbench/sef_remote_master.sv
`timescale 1ns/1ps
module sef_remote_master (
    output logic sck, // serial clock, still between frames
    output logic ss_n, // the only slave select, active low
    output logic mosi, // data towards the port
    input wire logic miso, // data from the port
    input wire logic pol, // clock polarity
    input wire logic pha // clock phase
);
    import sef_pkg::*;
    logic tog = 1'b0;
    assign sck = pol ^ tog;
    initial begin
        ss_n = 1'b1;
        mosi = 1'b0;
    end
    task automatic sel(input logic lvl);
        ss_n = lvl;
        mosi = ~mosi;
    endtask
    task automatic xfer(input sef_byte_t tx, output sef_byte_t rx);
        ss_n = 1'b0;
        mosi = tx[7];
        #10;
        for (int i = 7; i >= 0; i--) begin
            if (!pha) rx[i] = miso;
            tog = 1'b1;
            #1 if (pha) mosi = tx[i];
            #2 if (pha) rx[i] = miso;
            tog = 1'b0;
            #1 if (!pha && i > 0) mosi = tx[i-1];
            #2;
        end
        #2 ss_n = 1'b1;
        mosi = ~mosi;
    endtask
endmodule

// File: testbench/sef_port_tb.sv
`timescale 1ns/1ps
module sef_port_tb;
    import sef_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, halt = 1'b0, pol = 1'b0, pha = 1'b0;
    logic cr_wr = 1'b0, csr_rd = 1'b0, dr_wr = 1'b0, dr_rd = 1'b0;
    logic link_sck, ss_n, mosi_in, miso_out, mosi_out, irq, halt_wake;
    logic miso_oe, mosi_oe, sck_out, sck_oe;
    sef_byte_t wdata = 8'h00, cr_rdata, csr_rdata, dr_rdata, rx;
    int n_errors = 0, total_checks = 0;
    always #25 clk = ~clk;
    sef_remote_master u_far (.sck(link_sck), .ss_n(ss_n), .mosi(mosi_in),
        .miso(miso_out), .pol(pol), .pha(pha));
    // master data loops back from master-out to master-in
    sef_port u_sef_port (.clk(clk), .rst_n(rst_n), .link_sck(link_sck),
        .halt(halt), .cr_wr(cr_wr), .csr_rd(csr_rd), .dr_wr(dr_wr),
        .dr_rd(dr_rd), .wdata(wdata), .cr_rdata(cr_rdata),
        .csr_rdata(csr_rdata), .dr_rdata(dr_rdata), .irq(irq),
        .halt_wake(halt_wake), .ss_n(ss_n), .miso_in(mosi_out),
        .miso_out(miso_out), .miso_oe(miso_oe), .mosi_in(mosi_in),
        .mosi_out(mosi_out), .mosi_oe(mosi_oe), .sck_out(sck_out),
        .sck_oe(sck_oe));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input sef_byte_t got, input sef_byte_t exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // k: 0 control write, 1 status read, 2 data write, 3 data read
    task automatic pulse(input int k, input sef_byte_t d);
        @(posedge clk);
        wdata <= d;
        {cr_wr, csr_rd, dr_wr, dr_rd} <= 4'(1 << (3 - k));
        @(posedge clk);
        {cr_wr, csr_rd, dr_wr, dr_rd} <= 4'h0;
        #1;
    endtask
    task automatic wait_flag(input int b);
        int n = 0;
        while (csr_rdata[b] !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 400) begin
                n_errors++;
                $display("FAIL t=%0t got %h exp %h", $time, csr_rdata,
                         8'h01 << b);
                wrap_up();
            end
        end
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk(cr_rdata, 8'h00);
        chk(csr_rdata, 8'h00);
        for (int m = 0; m < 4; m++) begin
            pulse(0, 8'h00);
            {pol, pha} = 2'(m);
            pulse(0, {4'h4, 2'(m), 2'b00});
            pulse(2, 8'h5a ^ 8'(m));
            u_far.xfer(8'hc3 ^ 8'(m), rx);
            chk(rx, 8'h5a ^ 8'(m));
            wait_flag(7);
            chk(dr_rdata, 8'hc3 ^ 8'(m));
            pulse(1, 8'h00);
            pulse(3, 8'h00);
            chk(csr_rdata, 8'h00);
        end
        #300 u_far.xfer(8'h81, rx);
        chk(rx, 8'hc0);
        wait_flag(7);
        pulse(0, 8'hcc);
        #300 u_far.xfer(8'h7e, rx);
        wait_flag(5);
        chk(csr_rdata, 8'ha0);
        chk(dr_rdata, 8'h81);
        chk({7'h0, irq}, 8'h01);
        pulse(1, 8'h00);
        chk(csr_rdata, 8'h80);
        pulse(3, 8'h00);
        pulse(0, 8'h00);
        {pol, pha} = 2'b00;
        pulse(0, 8'hc0);
        u_far.sel(1'b0);
        repeat (4) @(posedge clk);
        pulse(2, 8'h3c);
        chk(csr_rdata, 8'h40);
        chk({7'h0, irq}, 8'h00);
        chk({7'h0, miso_oe}, 8'h01);
        u_far.sel(1'b1);
        pulse(1, 8'h00);
        pulse(3, 8'h00);
        chk(csr_rdata, 8'h00);
        pulse(0, 8'hd1);
        chk({5'h0, sck_out, sck_oe, mosi_oe}, 8'h03);
        pulse(2, 8'h96);
        wait_flag(7);
        chk(dr_rdata, 8'h96);
        pulse(1, 8'h00);
        pulse(3, 8'h00);
        u_far.sel(1'b0);
        wait_flag(4);
        chk(cr_rdata, 8'h81);
        chk({6'h0, sck_oe, mosi_oe}, 8'h00);
        chk({7'h0, irq}, 8'h01);
        pulse(0, 8'hd1);
        chk(cr_rdata, 8'h81);
        u_far.sel(1'b1);
        pulse(1, 8'h00);
        pulse(0, 8'hd1);
        chk(csr_rdata, 8'h00);
        chk(cr_rdata, 8'hd1);
        pulse(0, 8'h00);
        pulse(0, 8'h7e);
        chk({5'h0, sck_out, sck_oe, mosi_oe}, 8'h07);
        pulse(2, 8'ha5);
        wait_flag(7);
        chk(dr_rdata, 8'ha5);
        pulse(1, 8'h00);
        pulse(3, 8'h00);
        pulse(0, 8'h00);
        pulse(0, 8'hc0);
        @(posedge clk);
        halt <= 1'b1;
        pulse(0, 8'h00);
        chk(cr_rdata, 8'hc0);
        #300 u_far.xfer(8'h21, rx);
        #300 u_far.xfer(8'h42, rx);
        #300 chk(csr_rdata, 8'ha0);
        chk({7'h0, halt_wake}, 8'h01);
        @(posedge clk);
        halt <= 1'b0;
        @(posedge clk);
        #1;
        chk(dr_rdata, 8'h21);
        wrap_up();
    end
endmodule
